//--- pkg/scs_regs.svh
// Purpose: offsets, reset values, limits and timing counts of the speed command path
// Assumes: 16-bit parameter words at their communication addresses
// Notes:   definitions only
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

`define SCS_ADDR_LPF        16'h010c
`define SCS_ADDR_ACC        16'h0144
`define SCS_ADDR_DEC        16'h0146
`define SCS_ADDR_TSL        16'h0148

`define SCS_RST_LPF         16'h0000
`define SCS_RST_ACC         16'h00c8
`define SCS_RST_DEC         16'h00c8
`define SCS_RST_TSL         16'h0000

`define SCS_TIME_MIN        16'h0001
`define SCS_ACC_MAX         16'h4e20
`define SCS_TSL_MAX         16'h2710
`define SCS_LPF_MAX         16'h03e8
`define SCS_SCALE_MAX       16'h2710
`define SCS_PRESET_MAX      18'h0c350
// Analog full scale at the largest scale setting, 10000 r/min in counts
`define SCS_CMD_MAX         18'h186a0

// 3000 r/min expressed in 0.1 r/min counts
`define SCS_RAMP_SPAN       32'h00007530
// r/min to 0.1 r/min counts
`define SCS_RPM_TO_CNT      37'h000000000a
// Analog code full scale (+10 V) is 2^15
`define SCS_ANA_FS_SHIFT    15
`define SCS_LPF_SHIFT       10
`define SCS_FRAC_BITS       16

`define SCS_CLK_NS          25
`define SCS_MS_NS           1000000
`define SCS_CYC_PER_MS      (`SCS_MS_NS / `SCS_CLK_NS)
// Filter update period per ms of time constant, rounded down
`define SCS_LPF_CYC_PER_MS  (`SCS_CYC_PER_MS >> `SCS_LPF_SHIFT)

`endif

//--- pkg/scs_pkg.sv
// Purpose: types of the speed command path
// Assumes: command unit is 0.1 r/min
// Notes:   constants live in scs_regs.svh
package scs_pkg;

    typedef logic signed [17:0] scs_cmd_t;
    typedef logic [15:0]        scs_word_t;

    typedef enum logic [1:0] {
        SCS_MODE_S  = 2'b00,
        SCS_MODE_SZ = 2'b01,
        SCS_MODE_T  = 2'b10,
        SCS_MODE_TZ = 2'b11
    } scs_mode_t;

    typedef enum logic [1:0] {
        SCS_SRC_ANALOG = 2'b00,
        SCS_SRC_ZERO   = 2'b01,
        SCS_SRC_PRESET = 2'b10
    } scs_src_t;

endpackage

//--- pkg/scs_flt_if.sv
// Purpose: carrier between the command path and a first-order smoothing stage
// Assumes: one clock domain
// Notes:   tau in ms, zero means pass-through
`timescale 1ns/1ps
interface scs_flt_if;
    import scs_pkg::*;
    scs_cmd_t  x;
    scs_word_t tau;
    scs_cmd_t  y;

    modport src  (output x, output tau, input y);
    modport filt (input x, input tau, output y);
endinterface

//--- core/scs_flt.sv
// Purpose: first-order low-pass stage with time constant in ms
// Assumes: tau changes rarely; input x from same clock
// Notes:   step of 1/1024 of the error every tau*CYC_PER_UNIT cycles
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_flt #(
    parameter int unsigned CYC_PER_UNIT = 39
) (
    input  wire logic   i_core_clk,
    input  wire logic   i_resetn,
    scs_flt_if.filt     flt
);
    import scs_pkg::*;

    logic        [31:0] tick_cnt;
    logic        [31:0] tick_len;
    logic               tick;
    logic signed [34:0] y_fix;
    logic signed [34:0] x_fix;
    logic signed [34:0] err;

    assign tick_len = 32'(flt.tau) * 32'(CYC_PER_UNIT);
    assign tick     = (tick_cnt + 32'h00000001 >= tick_len);
    assign x_fix    = {flt.x[17], flt.x, 16'h0000};
    assign err      = x_fix - y_fix;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt <= 32'h00000000;
        end else if (flt.tau == 16'h0000 || tick) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    // 1024 updates of 1/1024 give roughly one time constant
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            y_fix <= 35'h000000000;
        end else if (flt.tau == 16'h0000) begin
            y_fix <= x_fix;
        end else if (tick) begin
            y_fix <= y_fix + (err >>> `SCS_LPF_SHIFT);
        end
    end

    assign flt.y = y_fix[33:16];

endmodule // scs_flt

//--- core/scs_top.sv
// Purpose: speed command select, S-curve shaping and command end low-pass filter
// Assumes: analog code is signed, +32767 near +10 V; presets, scale and mode come from the parameter store
// Notes:   command counts are 0.1 r/min
// Notes on behaviour
// R1 - With both select bits low the command is zero in zero speed mode and the scaled analog input otherwise.
// R2 - With a nonzero select code the command is preset 1, 2 or 3 for codes 01, 10 and 11.
// R3 - A new preset takes effect as soon as the select inputs change, with no trigger pulse.
// R4 - Presets are signed, limited to -50000..50000, one count being 0.1 r/min.
// R5 - The analog input spans -10 V..+10 V and is scaled to speed by the maximum analog speed setting.
// R6 - In torque modes the selected command is flagged as a speed limit instead of a target.
// R7 - Speed changes are shaped so that acceleration stays continuous.
// R8 - The acceleration time sets ms from 0 to 3000 r/min, accepts 1..20000, resets to 200.
// R9 - The deceleration time sets ms from 3000 r/min to 0, accepts 1..20000, resets to 200.
// R10 - The smoothing time sets the corner rounding in ms, accepts 0..10000, resets to 0 which disables it.
// R11 - With the analog source and zero smoothing time the S-curve shaping is bypassed.
// R12 - Acceleration, deceleration and smoothing settings are held independently.
// R13 - The analog command passes the same shaping profile with separate up and down slopes.
// R14 - A command end low-pass filter with time constant 0..1000 ms, reset 0 meaning disabled, follows.
// R15 - The command goes through the S-curve shaper first and the low-pass filter second.
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_top #(
    parameter int unsigned CYC_PER_MS = `SCS_CYC_PER_MS
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_speed_select_bit0,
    input  wire logic              i_speed_select_bit1,
    input  wire logic signed [15:0] i_analog_speed_ref,
    input  wire scs_pkg::scs_mode_t i_control_mode_select,
    input  wire scs_pkg::scs_cmd_t i_internal_speed_preset_1,
    input  wire scs_pkg::scs_cmd_t i_internal_speed_preset_2,
    input  wire scs_pkg::scs_cmd_t i_internal_speed_preset_3,
    input  wire scs_pkg::scs_word_t i_analog_max_speed_scale,
    input  wire logic [15:0]       i_par_addr,
    input  wire logic              i_par_wr,
    input  wire logic              i_par_rd,
    input  wire scs_pkg::scs_word_t i_par_wdata,
    output logic                   o_par_ack,
    output scs_pkg::scs_word_t     o_par_rdata,
    output scs_pkg::scs_cmd_t      o_speed_cmd,
    output logic                   o_cmd_is_limit,
    output scs_pkg::scs_src_t      o_cmd_source,
    output logic                   o_ramp_settled
);
    import scs_pkg::*;

    scs_word_t          analog_cmd_lowpass_time;
    scs_word_t          accel_time_const;
    scs_word_t          decel_time_const;
    scs_word_t          scurve_smoothing_time;

    logic [1:0]         sel_meta;
    logic [1:0]         sel_sync;
    logic [1:0]         sel_pins;

    scs_cmd_t           preset_1;
    scs_cmd_t           preset_2;
    scs_cmd_t           preset_3;
    scs_word_t          scale_c;
    logic signed [36:0] ana_prod;
    scs_cmd_t           ana_cmd;
    scs_cmd_t           target;
    scs_src_t           src;

    scs_cmd_t           ramp;
    logic [31:0]        ramp_acc;
    logic [31:0]        ramp_sum;
    logic [31:0]        ramp_lim;
    logic               use_accel;
    logic               bypass;

    scs_flt_if          smooth_if ();
    scs_flt_if          lpf_if ();

    function automatic scs_word_t clamp_word(scs_word_t v, scs_word_t lo, scs_word_t hi);
        scs_word_t r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic scs_cmd_t clamp_preset(scs_cmd_t v);
        scs_cmd_t r;
        r = v;
        if (v > $signed(`SCS_PRESET_MAX)) begin
            r = `SCS_PRESET_MAX;
        end else if (v < -$signed(`SCS_PRESET_MAX)) begin
            r = -$signed(`SCS_PRESET_MAX);
        end
        return r;
    endfunction

    // Select pins come from outside: two flops per bit before use
    assign sel_pins = {i_speed_select_bit1, i_speed_select_bit0};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sel_sync
            always_ff @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sel_meta[gi] <= 1'b0;
                    sel_sync[gi] <= 1'b0;
                end else begin
                    sel_meta[gi] <= sel_pins[gi];
                    sel_sync[gi] <= sel_meta[gi];
                end
            end
        end
    endgenerate

    // Parameter writes, out-of-range values are clamped, each word kept apart
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            analog_cmd_lowpass_time <= `SCS_RST_LPF;
            accel_time_const        <= `SCS_RST_ACC;
            decel_time_const        <= `SCS_RST_DEC;
            scurve_smoothing_time   <= `SCS_RST_TSL;
        end else if (i_par_wr) begin
            unique case (i_par_addr)
                `SCS_ADDR_LPF: begin
                    analog_cmd_lowpass_time <= clamp_word(i_par_wdata, 16'h0000, `SCS_LPF_MAX); // R14 R12
                end
                `SCS_ADDR_ACC: begin
                    accel_time_const <= clamp_word(i_par_wdata, `SCS_TIME_MIN, `SCS_ACC_MAX); // R8 R12
                end
                `SCS_ADDR_DEC: begin
                    decel_time_const <= clamp_word(i_par_wdata, `SCS_TIME_MIN, `SCS_ACC_MAX); // R9 R12
                end
                `SCS_ADDR_TSL: begin
                    scurve_smoothing_time <= clamp_word(i_par_wdata, 16'h0000, `SCS_TSL_MAX); // R10 R12
                end
                default: begin
                end
            endcase
        end
    end

    // Read answers one cycle later; unmapped addresses read zero
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_par_ack   <= 1'b0;
            o_par_rdata <= 16'h0000;
        end else begin
            o_par_ack <= i_par_rd | i_par_wr;
            if (i_par_rd) begin
                unique case (i_par_addr)
                    `SCS_ADDR_LPF: o_par_rdata <= analog_cmd_lowpass_time;
                    `SCS_ADDR_ACC: o_par_rdata <= accel_time_const;
                    `SCS_ADDR_DEC: o_par_rdata <= decel_time_const;
                    `SCS_ADDR_TSL: o_par_rdata <= scurve_smoothing_time;
                    default:       o_par_rdata <= 16'h0000;
                endcase
            end
        end
    end

    assign preset_1 = clamp_preset(i_internal_speed_preset_1); // R4
    assign preset_2 = clamp_preset(i_internal_speed_preset_2); // R4
    assign preset_3 = clamp_preset(i_internal_speed_preset_3); // R4
    assign scale_c  = clamp_word(i_analog_max_speed_scale, 16'h0000, `SCS_SCALE_MAX);

    // Full scale code maps to the maximum analog speed, in 0.1 r/min
    assign ana_prod = 37'(i_analog_speed_ref) * 37'($signed({1'b0, scale_c})) * `SCS_RPM_TO_CNT; // R5
    assign ana_cmd  = ana_prod[`SCS_ANA_FS_SHIFT +: 18]; // R5

    // Pure function of the synchronised pins, the mode and the source values, no trigger needed
    always_comb begin
        target = 18'h00000;
        src    = SCS_SRC_ZERO;
        unique case (sel_sync) // R3
            2'b00: begin
                if (i_control_mode_select == SCS_MODE_SZ || i_control_mode_select == SCS_MODE_TZ) begin
                    target = 18'h00000; // R1
                    src    = SCS_SRC_ZERO;
                end else begin
                    target = ana_cmd; // R1
                    src    = SCS_SRC_ANALOG;
                end
            end
            2'b01: begin
                target = preset_1; // R2
                src    = SCS_SRC_PRESET;
            end
            2'b10: begin
                target = preset_2; // R2
                src    = SCS_SRC_PRESET;
            end
            2'b11: begin
                target = preset_3; // R2
                src    = SCS_SRC_PRESET;
            end
        endcase
    end

    // Moving away from zero uses the accel slope, toward zero the decel slope
    assign use_accel = ((ramp >= 0) && (target > ramp)) || ((ramp <= 0) && (target < ramp)); // R13
    assign ramp_lim  = 32'(use_accel ? accel_time_const : decel_time_const) * 32'(CYC_PER_MS); // R8 R9
    assign ramp_sum  = ramp_acc + `SCS_RAMP_SPAN;
    assign bypass    = (src == SCS_SRC_ANALOG) && (scurve_smoothing_time == 16'h0000); // R11

    // Span is below one time unit of cycles, so at most one count per cycle
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ramp     <= 18'h00000;
            ramp_acc <= 32'h00000000;
        end else if (bypass) begin
            ramp     <= target; // R11
            ramp_acc <= 32'h00000000;
        end else if (ramp == target) begin
            ramp_acc <= 32'h00000000;
        end else if (ramp_sum >= ramp_lim) begin
            ramp_acc <= ramp_sum - ramp_lim; // R7
            if (target > ramp) begin
                ramp <= ramp + 18'h00001;
            end else begin
                ramp <= ramp - 18'h00001;
            end
        end else begin
            ramp_acc <= ramp_sum;
        end
    end

    // Rounding stage after the trapezoid keeps acceleration continuous
    assign smooth_if.x   = ramp; // R15
    assign smooth_if.tau = bypass ? 16'h0000 : scurve_smoothing_time; // R7 R10 R13

    scs_flt #(
        .CYC_PER_UNIT (CYC_PER_MS >> `SCS_LPF_SHIFT)
    ) u_smooth (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .flt        (smooth_if)
    );

    assign lpf_if.x   = smooth_if.y; // R15
    assign lpf_if.tau = analog_cmd_lowpass_time; // R14

    scs_flt #(
        .CYC_PER_UNIT (CYC_PER_MS >> `SCS_LPF_SHIFT)
    ) u_lpf (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .flt        (lpf_if)
    );

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_speed_cmd    <= 18'h00000;
            o_cmd_is_limit <= 1'b0;
            o_cmd_source   <= SCS_SRC_ANALOG;
            o_ramp_settled <= 1'b1;
        end else begin
            o_speed_cmd    <= lpf_if.y; // R15
            o_cmd_is_limit <= (i_control_mode_select == SCS_MODE_T) ||
                              (i_control_mode_select == SCS_MODE_TZ); // R6
            o_cmd_source   <= src;
            o_ramp_settled <= (ramp == target);
        end
    end

endmodule // scs_top

//--- bench/scs_top_assertions.sv
// Purpose: port checks of the speed command path
// Assumes: select contacts pass a two-flop synchroniser before the source register
// Notes:   six steady samples cover sync, source register and output stage
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_top_assertions (
    input wire logic               i_core_clk,
    input wire logic               i_resetn,
    input wire logic               i_speed_select_bit0,
    input wire logic               i_speed_select_bit1,
    input wire scs_pkg::scs_mode_t i_control_mode_select,
    input wire logic               i_par_wr,
    input wire logic               i_par_rd,
    input wire logic               o_par_ack,
    input wire scs_pkg::scs_word_t o_par_rdata,
    input wire scs_pkg::scs_cmd_t  o_speed_cmd,
    input wire logic               o_cmd_is_limit,
    input wire scs_pkg::scs_src_t  o_cmd_source
);
    import scs_pkg::*;
    wire logic [1:0] sel = {i_speed_select_bit1, i_speed_select_bit0};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    a_ack_after_strobe: assert property ((i_par_wr || i_par_rd) |=> o_par_ack)
        else $error("no acknowledge after a parameter strobe");
    a_ack_no_spurious: assert property (!(i_par_wr || i_par_rd) |=> !o_par_ack)
        else $error("acknowledge without a strobe");
    a_rdata_holds: assert property (!i_par_rd |=> $stable(o_par_rdata))
        else $error("read data moved without a read");
    a_limit_torque: assert property ((i_control_mode_select[1] [*2]) |-> o_cmd_is_limit)
        else $error("torque mode command not flagged as limit");
    a_target_speed: assert property ((!i_control_mode_select[1] [*2]) |-> !o_cmd_is_limit)
        else $error("speed mode command flagged as limit");
    a_zero_source: assert property (((sel == 2'b00 && i_control_mode_select[0]) [*6])
        |-> o_cmd_source == SCS_SRC_ZERO) else $error("zero source not chosen");
    a_analog_source: assert property (((sel == 2'b00 && !i_control_mode_select[0]) [*6])
        |-> o_cmd_source == SCS_SRC_ANALOG) else $error("analog source not chosen");
    a_preset_source: assert property (((sel != 2'b00) [*6]) |-> o_cmd_source == SCS_SRC_PRESET)
        else $error("preset source not chosen");
    a_cmd_bounded: assert property (o_speed_cmd <= $signed(`SCS_CMD_MAX)
        && o_speed_cmd >= -$signed(`SCS_CMD_MAX)) else $error("command beyond full scale range");
endmodule // scs_top_assertions

bind scs_top scs_top_assertions u_scs_top_assertions (
    .i_core_clk, .i_resetn, .i_speed_select_bit0, .i_speed_select_bit1, .i_control_mode_select,
    .i_par_wr, .i_par_rd, .o_par_ack, .o_par_rdata, .o_speed_cmd, .o_cmd_is_limit, .o_cmd_source);

//--- bench/scs_ctrl_model.sv
// Purpose: external controller driving the speed select contacts
// Assumes: contacts are asynchronous to the drive clock
// Notes:   bit1 trails bit0 by the lag, two relays rarely close together
`timescale 1ns/1ps
module scs_ctrl_model (
    input  wire logic       i_core_clk,
    input  wire logic [1:0] i_code,
    input  wire logic [3:0] i_lag,
    output logic            o_speed_select_bit0,
    output logic            o_speed_select_bit1
);
    initial begin
        o_speed_select_bit0 = 1'b0;
        o_speed_select_bit1 = 1'b0;
    end
    always @(i_code) begin
        repeat (i_lag) @(posedge i_core_clk);
        #7 o_speed_select_bit0 = i_code[0];
        repeat (i_lag) @(posedge i_core_clk);
        #3 o_speed_select_bit1 = i_code[1];
    end
endmodule // scs_ctrl_model

//--- bench/speed_command_select_smooth_tb.sv
// Purpose: self-checking bench of the speed command path
// Assumes: CYC_PER_MS cut to 30000, so a 1 ms ramp moves one count per cycle
// Notes:   register rows in a loop, ramp, preset and filter cases by hand
`timescale 1ns/1ps
`include "scs_regs.svh"
module speed_command_select_smooth_tb;
    import scs_pkg::*;
    localparam logic [47:0] ROWS [10] = '{{16'h0144, 16'h01f4, 16'h01f4}, {16'h0144, 16'h0000, 16'h0001},
        {16'h0144, 16'h7530, 16'h4e20}, {16'h0146, 16'h4e20, 16'h4e20}, {16'h0146, 16'h0000, 16'h0001},
        {16'h0148, 16'h2711, 16'h2710}, {16'h0148, 16'h0005, 16'h0005}, {16'h010c, 16'h03e9, 16'h03e8},
        {16'h010c, 16'h0000, 16'h0000}, {16'h0150, 16'h1234, 16'h0000}};
    localparam scs_cmd_t EXP_P [4] = '{18'h00000, 18'h3fc18, 18'h0c350, 18'h09c40};
    logic               clk, rstn, wr, rd, ack, lim, settled, b0, b1;
    logic [1:0]         code;
    logic [3:0]         lag;
    logic [15:0]        addr;
    logic signed [15:0] ana;
    scs_mode_t          mode;
    scs_src_t           src;
    scs_cmd_t           p1, p2, p3, cmd;
    scs_word_t          scale, wdata, rdata;
    int                 miscompares, comparisons, cycles;

    scs_top #(.CYC_PER_MS(30000)) u_scs_top (.i_core_clk(clk), .i_resetn(rstn), .i_speed_select_bit0(b0),
        .i_speed_select_bit1(b1), .i_analog_speed_ref(ana), .i_control_mode_select(mode),
        .i_internal_speed_preset_1(p1), .i_internal_speed_preset_2(p2), .i_internal_speed_preset_3(p3),
        .i_analog_max_speed_scale(scale), .i_par_addr(addr), .i_par_wr(wr), .i_par_rd(rd),
        .i_par_wdata(wdata), .o_par_ack(ack), .o_par_rdata(rdata), .o_speed_cmd(cmd),
        .o_cmd_is_limit(lim), .o_cmd_source(src), .o_ramp_settled(settled));
    scs_ctrl_model u_scs_ctrl_model (.i_core_clk(clk), .i_code(code), .i_lag(lag),
        .o_speed_select_bit0(b0), .o_speed_select_bit1(b1));

    task automatic test_done;
        $display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe for one edge; ack and read data land on it; one idle edge before the next call
    task automatic par(input logic w, input logic [15:0] a, input logic [15:0] d);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        step(1);
        chk({17'h0, ack}, 18'h00001);
        wr = 1'b0;
        rd = 1'b0;
        step(1);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        par(1'b0, a, 16'h0000);
        chk({2'h0, rdata}, {2'h0, exp});
    endtask
    // Bounded wait, since ramps only settle after their time constant
    task automatic settle(input scs_cmd_t exp, input int lim_cyc);
        int n;
        n = 0;
        while ((cmd !== exp || settled !== 1'b1) && n < lim_cyc) begin
            step(1);
            n++;
        end
        chk(cmd, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 85000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        {rstn, wr, rd, code, lag, addr, wdata, ana, scale, p1, p2, p3} = '0;
        mode = SCS_MODE_SZ;
        step(12);
        rstn = 1'b1;
        rdchk(`SCS_ADDR_ACC, `SCS_RST_ACC);
        rdchk(`SCS_ADDR_DEC, `SCS_RST_DEC);
        rdchk(`SCS_ADDR_TSL, `SCS_RST_TSL);
        rdchk(`SCS_ADDR_LPF, `SCS_RST_LPF);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            par(1'b1, ROWS[i][47:32], ROWS[i][31:16]);
            rdchk(ROWS[i][47:32], ROWS[i][15:0]);
        end
        rdchk(`SCS_ADDR_ACC, 16'h4e20);
        $display("test register rows done");
        par(1'b1, `SCS_ADDR_ACC, 16'h0002);
        par(1'b1, `SCS_ADDR_TSL, 16'h0000);
        settle(18'h00000, 20);
        chk({16'h0, src}, {16'h0, SCS_SRC_ZERO});
        // 2 ms per 3000 r/min: 1000 counts take 2000 cycles
        p1 = 18'h003e8;
        code = 2'b01;
        step(1950);
        chk({17'h0, settled}, 18'h00000);
        settle(18'h003e8, 100);
        par(1'b1, `SCS_ADDR_DEC, 16'h0003);
        code = 2'b00;
        step(2950);
        chk({17'h0, settled}, 18'h00000);
        settle(18'h00000, 100);
        $display("test ramp timing done");
        lag = 4'h3;
        par(1'b1, `SCS_ADDR_ACC, 16'h0001);
        par(1'b1, `SCS_ADDR_DEC, 16'h0001);
        p1 = 18'h3fc18;
        p2 = 18'h0ea60;
        p3 = 18'h09c40;
        for (int c = 1; c < 4; c++) begin
            code = c[1:0];
            settle(EXP_P[c], 52000);
            chk({16'h0, src}, {16'h0, SCS_SRC_PRESET});
        end
        $display("test preset select done");
        mode = SCS_MODE_T;
        step(3);
        chk({17'h0, lim}, 18'h00001);
        mode = SCS_MODE_TZ;
        step(3);
        chk({17'h0, lim}, 18'h00001);
        mode = SCS_MODE_S;
        step(3);
        chk({17'h0, lim}, 18'h00000);
        $display("test torque limit done");
        lag = 4'h0;
        code = 2'b00;
        scale = 16'h0bb8;
        ana = 16'h4000;
        settle(18'h03a98, 20);
        chk({16'h0, src}, {16'h0, SCS_SRC_ANALOG});
        par(1'b1, `SCS_ADDR_LPF, 16'h0001);
        ana = 16'hc000;
        step(10);
        chk({17'h0, cmd === 18'h3c568}, 18'h00000);
        // A tenth of the 1 ms time constant: about 9.5 percent of the 30000 count step
        step(2990);
        chk({17'h0, (cmd > 18'sh02cec) && (cmd < 18'sh03200)}, 18'h00001);
        par(1'b1, `SCS_ADDR_LPF, 16'h0000);
        settle(18'h3c568, 20);
        $display("test analog path done");
        rstn = 1'b0;
        step(2);
        chk(cmd, 18'h00000);
        chk({17'h0, settled}, 18'h00001);
        chk({16'h0, src}, {16'h0, SCS_SRC_ANALOG});
        rstn = 1'b1;
        rdchk(`SCS_ADDR_ACC, `SCS_RST_ACC);
        rdchk(`SCS_ADDR_LPF, `SCS_RST_LPF);
        $display("test second reset done");
        test_done();
    end
endmodule // speed_command_select_smooth_tb
